// [src/irc_pkg.sv]
// Shared constants and carrier types for the isochronous receive context filter
`default_nettype none
package irc_pkg;
    localparam int IRC_NUM_CTX = 4;
    localparam int IRC_ADDR_W = 16;

    // Register map, byte addresses, one context every stride
    localparam logic [15:0] IRC_CTX_STRIDE = 16'h0020;
    localparam logic [15:0] IRC_CTRL_BASE = 16'h0400;
    localparam logic [15:0] IRC_PTR_SET_BASE = 16'h0408;
    localparam logic [15:0] IRC_PTR_BASE = 16'h040C;
    localparam logic [15:0] IRC_FILT_BASE = 16'h410C;
    localparam logic [15:0] IRC_CHMASK_HI = 16'h0070;
    localparam logic [15:0] IRC_CHMASK_LO = 16'h0078;

    // Packet filter fields
    localparam int IRC_F_ACCEPT_TAG_ZERO_BIT = 28;
    localparam int IRC_F_CYC_LO = 12;
    localparam int IRC_F_CYC_HI = 26;
    localparam int IRC_F_SYNC_LO = 8;
    localparam int IRC_F_SYNC_HI = 11;
    localparam int IRC_F_T1SYNC_BIT = 6;
    localparam int IRC_F_CHAN_LO = 0;
    localparam int IRC_F_CHAN_HI = 5;
    localparam logic [31:0] IRC_FILT_WR_MASK = 32'hF7FF_FF7F;
    localparam logic [31:0] IRC_FILT_RESET = 32'h0000_0000;

    // Context control fields
    localparam int IRC_C_SOC_BIT = 29;
    localparam int IRC_C_ALLCH_BIT = 28;
    localparam int IRC_C_WSEL_LO = 16;
    localparam int IRC_C_RUN_BIT = 15;
    localparam int IRC_C_ACTIVE_BIT = 10;
    localparam int IRC_C_RXEN_BIT = 9;
    localparam int IRC_C_SYNCED_BIT = 8;
    localparam logic [1:0] IRC_WAIT_FOR_SYNC = 2'h3;

    // Cycle timer bits compared against the start-cycle field
    localparam int IRC_CT_LO = 12;
    localparam int IRC_CT_HI = 26;

    localparam logic [31:0] IRC_PTR_RESET = 32'h0000_0000;
    localparam logic [63:0] IRC_CHMASK_RESET = 64'h0000_0000_0000_0000;

    typedef enum logic {
        IRC_FST_IDLE = 1'b0,
        IRC_FST_WAIT = 1'b1
    } irc_fetch_state_type;

    typedef struct packed {
        logic [5:0] channel;
        logic [1:0] tag;
        logic [3:0] sync;
    } irc_pkt_type;

    typedef struct packed {
        logic [1:0] ctx;
        irc_pkt_type pkt;
    } irc_acc_type;

    typedef struct packed {
        logic [1:0] ctx;
        logic [31:0] addr;
    } irc_fetch_type;
endpackage
`default_nettype wire

// [src/irc_pair_buffer.sv]
// Two-entry buffer with registered outputs on both sides
`default_nettype none
module irc_pair_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
        logic [1:0] count;
        logic in_ready;
        logic out_valid;
    } irc_buf_state_type;

    irc_buf_state_type r, n;
    logic push;
    logic pop;

    assign push = in_valid_i & r.in_ready;
    assign pop = r.out_valid & out_ready_i;

    always_comb begin
        n = r;
        if (push && pop) begin
            if (r.count == 2'h1) begin
                n.head = in_data_i;
            end else begin
                n.head = r.tail;
                n.tail = in_data_i;
            end
        end else if (pop) begin
            n.head = r.tail;
            n.count = r.count - 2'h1;
        end else if (push) begin
            if (r.count == 2'h0) begin
                n.head = in_data_i;
            end else begin
                n.tail = in_data_i;
            end
            n.count = r.count + 2'h1;
        end
        // Ready is taken from the next count so a full buffer refuses at once
        n.in_ready = (n.count != 2'h2);
        n.out_valid = (n.count != 2'h0);
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign in_ready_o = r.in_ready;
    assign out_valid_o = r.out_valid;
    assign out_data_o = r.head;
endmodule
`default_nettype wire

// [src/irc_context_filter.sv]
// Isochronous receive contexts: start pointers, packet filters and register slave
//
// The Avalon-MM register port was decided locally.
`default_nettype none
module irc_context_filter
    import irc_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Avalon-MM register slave
    input wire logic [IRC_ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Packets from the link layer
    input wire logic PKT_VALID_I,
    output logic PKT_READY_O,
    input wire irc_pkt_type PKT_I,
    input wire logic [31:0] CYCLE_TIMER_I,
    // Accepted packets towards the receive DMA
    output logic ACC_VALID_O,
    input wire logic ACC_READY_I,
    output irc_acc_type ACC_O,
    // Descriptor fetch requests
    output logic FETCH_VALID_O,
    input wire logic FETCH_READY_I,
    output irc_fetch_type FETCH_O
);
    typedef struct packed {
        // Bus slave
        logic wait_req;
        logic [31:0] rdata;
        // Software-visible registers, plus the internal delayed run copy run_q
        logic [IRC_NUM_CTX-1:0][31:0] ptr;
        logic [IRC_NUM_CTX-1:0][31:0] filt;
        logic [IRC_NUM_CTX-1:0] run;
        logic [IRC_NUM_CTX-1:0] run_q;
        logic [IRC_NUM_CTX-1:0] soc;
        logic [IRC_NUM_CTX-1:0] allch;
        logic [IRC_NUM_CTX-1:0][1:0] wsel;
        // Per-context status, then the shared channel mask
        logic [IRC_NUM_CTX-1:0] pend;
        logic [IRC_NUM_CTX-1:0] active;
        logic [IRC_NUM_CTX-1:0] rx_en;
        logic [IRC_NUM_CTX-1:0] synced;
        logic [63:0] chmask;
        // Fetch request
        irc_fetch_state_type fst;
        logic fvalid;
        irc_fetch_type fetch;
    } irc_state_type;

    irc_state_type r, n;

    logic [IRC_NUM_CTX-1:0] hit;
    logic [IRC_NUM_CTX-1:0] sel;
    logic [IRC_NUM_CTX-1:0] need_sync;
    logic [IRC_NUM_CTX-1:0] cyc_hit;
    logic [1:0] sel_ctx;
    logic take;
    logic push;
    logic buf_in_ready;
    irc_acc_type acc_in;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] ctx_addr(input logic [15:0] base, input int idx);
        ctx_addr = base + 16'(idx) * IRC_CTX_STRIDE;
    endfunction

    // Byte lanes merged so partial writes leave the other lanes alone
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        merge = res;
    endfunction

    function automatic logic [31:0] ctrl_word(input irc_state_type s, input int idx);
        logic [31:0] w;
        w = '0;
        w[IRC_C_SOC_BIT] = s.soc[idx];
        w[IRC_C_ALLCH_BIT] = s.allch[idx];
        w[IRC_C_WSEL_LO +: 2] = s.wsel[idx];
        w[IRC_C_RUN_BIT] = s.run[idx];
        w[IRC_C_ACTIVE_BIT] = s.active[idx];
        w[IRC_C_RXEN_BIT] = s.rx_en[idx];
        w[IRC_C_SYNCED_BIT] = s.synced[idx];
        ctrl_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register address decode

    logic [IRC_NUM_CTX-1:0] at_ptr;
    logic [IRC_NUM_CTX-1:0] at_ptr_set;
    logic [IRC_NUM_CTX-1:0] at_filt;
    logic [IRC_NUM_CTX-1:0] at_ctrl;
    logic at_mask_hi;
    logic at_mask_lo;

    genvar d;
    generate
        for (d = 0; d < IRC_NUM_CTX; d++) begin : g_dec
            assign at_ptr[d] = (AVS_ADDRESS_I == ctx_addr(IRC_PTR_BASE, d));
            assign at_ptr_set[d] = (AVS_ADDRESS_I == ctx_addr(IRC_PTR_SET_BASE, d));
            assign at_filt[d] = (AVS_ADDRESS_I == ctx_addr(IRC_FILT_BASE, d));
            assign at_ctrl[d] = (AVS_ADDRESS_I == ctx_addr(IRC_CTRL_BASE, d));
        end
    endgenerate

    assign at_mask_hi = (AVS_ADDRESS_I == IRC_CHMASK_HI);
    assign at_mask_lo = (AVS_ADDRESS_I == IRC_CHMASK_LO);

    ////////////////////////////////////////////////////////////////////////////
    // Per-context packet match

    genvar g;
    generate
        for (g = 0; g < IRC_NUM_CTX; g++) begin : g_ctx
            logic chan_ok;
            logic tag_ok;
            logic t1_ok;
            logic sync_ok;
            assign chan_ok = r.allch[g] ? r.chmask[PKT_I.channel]
                : (PKT_I.channel == r.filt[g][IRC_F_CHAN_HI:IRC_F_CHAN_LO]);
            assign tag_ok = r.filt[g][IRC_F_ACCEPT_TAG_ZERO_BIT + int'(PKT_I.tag)];
            // Extra sync test only for tag 01b with its enable set
            assign t1_ok = !(r.filt[g][IRC_F_T1SYNC_BIT] && (PKT_I.tag == 2'h1))
                || (PKT_I.sync[3:2] == 2'h0);

            // Sync gate falls away once the first sync match is in
            assign need_sync[g] = (r.wsel[g] == IRC_WAIT_FOR_SYNC) && !r.synced[g];
            assign sync_ok = !need_sync[g]
                || (PKT_I.sync == r.filt[g][IRC_F_SYNC_HI:IRC_F_SYNC_LO]);
            assign cyc_hit[g] = (CYCLE_TIMER_I[IRC_CT_HI:IRC_CT_LO]
                == r.filt[g][IRC_F_CYC_HI:IRC_F_CYC_LO]);
            assign hit[g] = r.rx_en[g] && chan_ok && tag_ok && t1_ok && sync_ok;
        end
    endgenerate

    // Lowest numbered context wins when several match
    always_comb begin
        sel = '0;
        sel_ctx = 2'h0;
        for (int i = IRC_NUM_CTX - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel = '0;
                sel[i] = 1'b1;
                sel_ctx = 2'(i);
            end
        end
    end

    // Packets that match nothing are consumed and dropped
    assign take = PKT_VALID_I & buf_in_ready;
    assign push = take & (|hit);
    assign acc_in.ctx = sel_ctx;
    assign acc_in.pkt = PKT_I;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] rd_val;
        logic [31:0] cw;
        logic wr_go;
        logic fetch_done;
        rd_val = '0;
        cw = '0;
        wr_go = 1'b0;
        fetch_done = 1'b0;
        n = r;

        // Bus: one wait cycle, then a cycle with waitrequest low completes the access
        n.wait_req = !((AVS_READ_I || AVS_WRITE_I) && r.wait_req);
        wr_go = AVS_WRITE_I && !r.wait_req;

        // Read mux; unmapped addresses read as zero
        if (at_mask_hi) begin
            rd_val = r.chmask[63:32];
        end
        if (at_mask_lo) begin
            rd_val = r.chmask[31:0];
        end
        for (int i = 0; i < IRC_NUM_CTX; i++) begin
            if (at_ptr[i]) begin
                rd_val = r.ptr[i];
            end
            if (at_filt[i]) begin
                rd_val = r.filt[i] & IRC_FILT_WR_MASK;
            end
            if (at_ctrl[i]) begin
                rd_val = ctrl_word(r, i);
            end
        end

        // Latched on the taking edge so it stands through the answer cycle
        if (AVS_READ_I && r.wait_req) begin
            n.rdata = rd_val;
        end

        if (wr_go && at_mask_hi) begin
            n.chmask[63:32] = merge(r.chmask[63:32], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end
        if (wr_go && at_mask_lo) begin
            n.chmask[31:0] = merge(r.chmask[31:0], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end

        // Per-context control, pending fetch and receive enables
        fetch_done = r.fvalid && FETCH_READY_I;
        // Delayed run copy gives a one-cycle rising-edge pulse
        n.run_q = r.run;
        for (int i = 0; i < IRC_NUM_CTX; i++) begin
            // Pointer is read-only at its own address; loaded through the IRC_PTR_SET_BASE address
            if (wr_go && at_ptr_set[i]) begin
                n.ptr[i] = merge(r.ptr[i], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            end
            if (wr_go && at_filt[i]) begin
                n.filt[i] = merge(r.filt[i], AVS_WRITEDATA_I, AVS_BYTEENABLE_I) & IRC_FILT_WR_MASK;
            end
            if (wr_go && at_ctrl[i]) begin
                cw = merge(ctrl_word(r, i), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                n.soc[i] = cw[IRC_C_SOC_BIT];
                n.allch[i] = cw[IRC_C_ALLCH_BIT];
                n.wsel[i] = cw[IRC_C_WSEL_LO +: 2];
                n.run[i] = cw[IRC_C_RUN_BIT];
            end

            // Run rising starts a fetch; the set wins over the completion
            if (fetch_done && r.fetch.ctx == 2'(i)) begin
                n.pend[i] = 1'b0;
            end
            if (r.run[i] && !r.run_q[i]) begin
                n.pend[i] = 1'b1;
            end

            if (!r.run[i]) begin
                n.active[i] = 1'b0;
                n.rx_en[i] = 1'b0;
                n.synced[i] = 1'b0;
                n.pend[i] = 1'b0;
            end else begin
                if (fetch_done && r.fetch.ctx == 2'(i)) begin
                    n.active[i] = 1'b1;
                end
                // Reception waits for the descriptor and, if asked, the start cycle
                if (r.active[i] && (!r.soc[i] || cyc_hit[i])) begin
                    n.rx_en[i] = 1'b1;
                end
                // After the first sync match the context no longer checks the sync field
                if (push && sel[i] && need_sync[i]) begin
                    n.synced[i] = 1'b1;
                end
            end
        end

        // One fetch in flight; lowest pending context goes first
        unique case (r.fst)
            IRC_FST_IDLE: begin
                for (int i = IRC_NUM_CTX - 1; i >= 0; i--) begin
                    if (r.pend[i] && r.run[i]) begin
                        n.fetch.ctx = 2'(i);
                        n.fetch.addr = r.ptr[i];
                        n.fvalid = 1'b1;
                        n.fst = IRC_FST_WAIT;
                    end
                end
            end
            IRC_FST_WAIT: begin
                // A request once raised is held until taken, even if run drops
                if (fetch_done) begin
                    n.fvalid = 1'b0;
                    n.fst = IRC_FST_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            r <= '0;
            r.wait_req <= 1'b1;
            // Filters clear so an unprogrammed context accepts no tag
            for (int i = 0; i < IRC_NUM_CTX; i++) begin
                r.ptr[i] <= IRC_PTR_RESET;
                r.filt[i] <= IRC_FILT_RESET;
            end
            r.chmask <= IRC_CHMASK_RESET;
            r.fst <= IRC_FST_IDLE;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer and ports

    irc_pair_buffer #(
        .WIDTH($bits(irc_acc_type))
    ) u_buf (
        .CLK_I(CLK_I),
        .RESET_I(RESET_I),
        .in_valid_i(push),
        .in_ready_o(buf_in_ready),
        .in_data_i(acc_in),
        .out_valid_o(ACC_VALID_O),
        .out_ready_i(ACC_READY_I),
        .out_data_o(ACC_O)
    );

    // Every port below is a register output
    assign PKT_READY_O = buf_in_ready;
    assign AVS_READDATA_O = r.rdata;
    assign AVS_WAITREQUEST_O = r.wait_req;
    assign FETCH_VALID_O = r.fvalid;
    assign FETCH_O = r.fetch;
endmodule
`default_nettype wire

// [verif/irc_context_filter_chk.sv]
// Port checks for the isochronous receive context filter
`default_nettype none
module irc_context_filter_chk
    import irc_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Register bus
    input wire logic [IRC_ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    // Streams
    input wire logic PKT_READY_O,
    input wire logic ACC_VALID_O,
    input wire logic ACC_READY_I,
    input wire irc_acc_type ACC_O,
    input wire logic FETCH_VALID_O,
    input wire logic FETCH_READY_I,
    input wire irc_fetch_type FETCH_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    logic [15:0] rel;
    assign rel = AVS_ADDRESS_I - IRC_FILT_BASE;
    ////////////////////////////////////////
    sequence s_req;
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
    endsequence
    sequence s_rd_done;
        AVS_READ_I && !AVS_WAITREQUEST_O;
    endsequence
    sequence s_rst_exit;
        $past(RESET_I) && !RESET_I;
    endsequence
    ////////////////////////////////////////
    a_wait_one: assert property (s_req |=> !AVS_WAITREQUEST_O) else $error("bus answer late");
    a_wait_drop: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("wait low too long");
    a_wait_idle: assert property (!AVS_READ_I && !AVS_WRITE_I && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("answer without request");
    a_filt_rsvd: assert property (s_rd_done and (rel < 16'h0080 && rel[4:0] == 5'h00) |->
        AVS_READDATA_O[27] == 1'b0 && AVS_READDATA_O[7] == 1'b0) else $error("reserved filter bit set");
    a_unmapped_zero: assert property (s_rd_done and AVS_ADDRESS_I[15:12] == 4'h2 |-> AVS_READDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_acc_held: assert property (ACC_VALID_O && !ACC_READY_I |=> ACC_VALID_O && $stable(ACC_O))
        else $error("accepted packet dropped");
    a_fetch_held: assert property (FETCH_VALID_O && !FETCH_READY_I |=> FETCH_VALID_O && $stable(FETCH_O))
        else $error("fetch request dropped");
    a_reset_exit: assert property (s_rst_exit |-> AVS_WAITREQUEST_O && !ACC_VALID_O && !FETCH_VALID_O
        && !PKT_READY_O ##1 PKT_READY_O) else $error("bad state after reset");
endmodule
bind irc_context_filter irc_context_filter_chk chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PKT_READY_O(PKT_READY_O),
    .ACC_VALID_O(ACC_VALID_O), .ACC_READY_I(ACC_READY_I), .ACC_O(ACC_O), .FETCH_VALID_O(FETCH_VALID_O),
    .FETCH_READY_I(FETCH_READY_I), .FETCH_O(FETCH_O));
`default_nettype wire

// [verif/irc_link_model.sv]
// Link layer and receive DMA stand-in around the filter
`default_nettype none
module irc_link_model
    import irc_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Packet headers into the filter
    output logic pkt_valid_o,
    input wire logic pkt_ready_i,
    output irc_pkt_type pkt_o,
    // Accepted packets and fetches out of the filter
    input wire logic acc_valid_i,
    output logic acc_ready_o,
    input wire irc_acc_type acc_i,
    input wire logic fetch_valid_i,
    output logic fetch_ready_o,
    input wire irc_fetch_type fetch_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall = 1'b0;
    logic hang = 1'b0;
    irc_acc_type got[$];
    irc_fetch_type fetches[$];
    initial begin
        pkt_valid_o = 1'b0;
        pkt_o = '0;
        fetch_ready_o = 1'b0;
    end
    assign acc_ready_o = !stall;
    // Fetch side answers every other cycle, so slow grants get exercised
    always @(posedge clk_i) begin
        fetch_ready_o <= ~fetch_ready_o;
        if (acc_valid_i && acc_ready_o) got.push_back(acc_i);
        if (fetch_valid_i && fetch_ready_o) fetches.push_back(fetch_i);
    end
    task automatic send(input irc_pkt_type p);
        int n;
        pkt_valid_o <= 1'b1;
        pkt_o <= p;
        n = 0;
        @(posedge clk_i);
        while (!pkt_ready_i && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) hang = 1'b1;
        pkt_valid_o <= 1'b0;
        // Released header lines must not keep the old value
        pkt_o <= ~p;
    endtask
endmodule
`default_nettype wire

// [verif/tb_irc_context_filter.sv]
// Self-checking bench for the isochronous receive context filter
`default_nettype none
module tb_irc_context_filter
    import irc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] ctime = 32'h0000_0000;
    logic [31:0] rdata;
    logic waitreq, pkt_valid, pkt_ready, acc_valid, acc_ready, fetch_valid, fetch_ready;
    irc_pkt_type pkt;
    irc_acc_type acc;
    irc_fetch_type fetch;
    logic refused = 1'b0;
    int errors = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (pkt_valid && !pkt_ready) refused <= 1'b1;
    irc_context_filter dut_u (.CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(waitreq), .PKT_VALID_I(pkt_valid), .PKT_READY_O(pkt_ready), .PKT_I(pkt),
        .CYCLE_TIMER_I(ctime), .ACC_VALID_O(acc_valid), .ACC_READY_I(acc_ready), .ACC_O(acc),
        .FETCH_VALID_O(fetch_valid), .FETCH_READY_I(fetch_ready), .FETCH_O(fetch));
    irc_link_model link_u (.clk_i(clk), .pkt_valid_o(pkt_valid), .pkt_ready_i(pkt_ready), .pkt_o(pkt),
        .acc_valid_i(acc_valid), .acc_ready_o(acc_ready), .acc_i(acc), .fetch_valid_i(fetch_valid),
        .fetch_ready_o(fetch_ready), .fetch_i(fetch));
    // A stuck link ends the run at once
    always @(posedge link_u.hang) begin
        errors++;
        summarize();
    end
    ////////////////////////////////////////
    task automatic summarize();
        $display("Counts: %0d checks, %0d errors", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] off(input int n);
        return 16'(n * 32'(IRC_CTX_STRIDE));
    endfunction
    // Idle edge first, so back-to-back calls never drive a strobe twice at once
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        n = 0;
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            errors++;
            summarize();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask
    task automatic start(input int n, input logic [31:0] flags, input logic [31:0] ptr);
        int k;
        irc_fetch_type f;
        link_u.fetches.delete();
        wreg(IRC_PTR_SET_BASE + off(n), ptr);
        rchk("pointer", IRC_PTR_BASE + off(n), ptr);
        wreg(IRC_CTRL_BASE + off(n), flags | 32'h0000_8000);
        k = 0;
        while (link_u.fetches.size() == 0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            errors++;
            summarize();
        end
        f = link_u.fetches[0];
        check("fetch addr", f.addr, ptr);
        check("fetch ctx", 32'(f.ctx), 32'(n));
        repeat (4) @(posedge clk);
    endtask
    task automatic pkt_chk(input logic [5:0] ch, input logic [1:0] tg, input logic [3:0] sy, input logic ok,
        input logic [1:0] cx);
        link_u.got.delete();
        link_u.send('{ch, tg, sy});
        repeat (6) @(posedge clk);
        check("accepted", 32'(link_u.got.size()), 32'(ok));
        if (ok && link_u.got.size() > 0) check("routed", 32'(link_u.got[0]), {18'h0, cx, ch, tg, sy});
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        rchk("filter reset", IRC_FILT_BASE + off(1), 32'h0);
        wreg(IRC_FILT_BASE + off(1), 32'hFFFF_FFFF);
        rchk("filter bits", IRC_FILT_BASE + off(1), 32'hF7FF_FF7F);
        wreg(IRC_PTR_BASE, 32'hFFFF_FFFF);
        rchk("pointer ro", IRC_PTR_BASE, 32'h0);
        rchk("unmapped", 16'h2000, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_tags();
        start(0, 32'h0, 32'h1000_0040);
        for (int t = 0; t < 4; t++) begin
            wreg(IRC_FILT_BASE, (32'h1000_0000 << t) | 32'h5);
            pkt_chk(6'd5, 2'(t), 4'h0, 1'b1, 2'd0);
            pkt_chk(6'd5, 2'(t + 1), 4'h0, 1'b0, 2'd0);
        end
        pkt_chk(6'd6, 2'd3, 4'h0, 1'b0, 2'd0);
        wreg(IRC_FILT_BASE, 32'h6000_0045);
        pkt_chk(6'd5, 2'd1, 4'h3, 1'b1, 2'd0);
        pkt_chk(6'd5, 2'd1, 4'h4, 1'b0, 2'd0);
        pkt_chk(6'd5, 2'd2, 4'hC, 1'b1, 2'd0);
        wreg(IRC_FILT_BASE, 32'h2000_0005);
        pkt_chk(6'd5, 2'd1, 4'hC, 1'b1, 2'd0);
        $display("t_tags done");
    endtask
    task automatic t_sync_cycle();
        wreg(IRC_FILT_BASE + off(1), 32'h1000_0A09);
        start(1, 32'h0003_0000, 32'h2000_0080);
        pkt_chk(6'd9, 2'd0, 4'h5, 1'b0, 2'd1);
        pkt_chk(6'd9, 2'd0, 4'hA, 1'b1, 2'd1);
        pkt_chk(6'd9, 2'd0, 4'h5, 1'b1, 2'd1);
        wreg(IRC_FILT_BASE + off(2), 32'h11AB_C00C);
        start(2, 32'h2000_0000, 32'h3000_00C0);
        ctime <= 32'h01AB_D000;
        pkt_chk(6'd12, 2'd0, 4'h0, 1'b0, 2'd2);
        ctime <= 32'h01AB_C000;
        repeat (2) @(posedge clk);
        ctime <= 32'h0;
        pkt_chk(6'd12, 2'd0, 4'h0, 1'b1, 2'd2);
        $display("t_sync_cycle done");
    endtask
    task automatic t_allch();
        wreg(IRC_CHMASK_LO, 32'h0010_0000);
        wreg(IRC_FILT_BASE + off(3), 32'h1000_0028);
        start(3, 32'h1000_0000, 32'h4000_0100);
        pkt_chk(6'd20, 2'd0, 4'h0, 1'b1, 2'd3);
        pkt_chk(6'd40, 2'd0, 4'h0, 1'b0, 2'd3);
        wreg(IRC_CHMASK_HI, 32'h0000_0100);
        rchk("mask hi", IRC_CHMASK_HI, 32'h0000_0100);
        pkt_chk(6'd40, 2'd0, 4'h0, 1'b1, 2'd3);
        $display("t_allch done");
    endtask
    task automatic t_stall();
        link_u.got.delete();
        link_u.stall <= 1'b1;
        fork
            begin
                repeat (12) @(posedge clk);
                link_u.stall <= 1'b0;
            end
        join_none
        for (int i = 0; i < 5; i++) begin
            link_u.send('{6'd5, 2'd1, 4'(i)});
            @(posedge clk);
        end
        repeat (8) @(posedge clk);
        check("refused", 32'(refused), 32'h1);
        check("link hang", 32'(link_u.hang), 32'h0);
        check("count", 32'(link_u.got.size()), 32'd5);
        for (int i = 0; i < link_u.got.size(); i++) check("order", 32'(link_u.got[i].pkt.sync), 32'(i));
        $display("t_stall done");
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_tags();
        t_sync_cycle();
        t_allch();
        t_stall();
        summarize();
    end
endmodule
`default_nettype wire
